/* File: hdl/ssci_pkg.sv */
// constants, field positions and state encoding for the synthesizer control interface
package ssci_pkg;

    // ------------------------------------------------------------
    // bus address
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED = 5'h18;
    localparam logic RW_READ = 1'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 10000;
    localparam int XTAL_DIV = 512;
    localparam int PRESCALE = 16;
    localparam int LOCK_SET_US = 1024;
    // least time, rounded up to whole cycles
    localparam int LOCK_SET_CYCLES = (LOCK_SET_US * CLK_KHZ + 999) / 1000;

    // ------------------------------------------------------------
    // write byte indices and fields
    // ------------------------------------------------------------
    localparam logic [1:0] IDX_DIV_HI = 2'h0;
    localparam logic [1:0] IDX_DIV_LO = 2'h1;
    localparam logic [1:0] IDX_PUMP = 2'h2;
    localparam logic [1:0] IDX_PORT = 2'h3;
    localparam int DATA_SEL_BIT = 7;
    localparam int PUMP_CURRENT_BIT = 6;
    localparam int TEST_ROUTE_BIT = 5;
    localparam int PUMP_TRISTATE_BIT = 4;
    localparam int DRIVE_AMP_OFF_BIT = 0;
    localparam int PB_SEVEN = 7;
    localparam int PB_CONV = 6;
    localparam int PB_FIVE = 5;
    localparam int PB_FOUR = 4;
    localparam int PB_ADDR = 3;
    localparam int PB_ZERO = 0;
    localparam logic [7:0] PUMP_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [14:0] RATIO_RESET = 15'h0000;

    // ------------------------------------------------------------
    // converter band codes, highest band first
    // ------------------------------------------------------------
    localparam logic [2:0] CONV_B4 = 3'h4;
    localparam logic [2:0] CONV_B3 = 3'h3;
    localparam logic [2:0] CONV_B2 = 3'h2;
    localparam logic [2:0] CONV_B1 = 3'h1;
    localparam logic [2:0] CONV_B0 = 3'h0;

    // ------------------------------------------------------------
    // serial state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SSCI_IDLE = 3'h0,
        SSCI_ADDR = 3'h1,
        SSCI_ADDR_ACK = 3'h3,
        SSCI_WR = 3'h2,
        SSCI_WR_ACK = 3'h6,
        SSCI_RD = 3'h7,
        SSCI_RD_ACK = 3'h5,
        SSCI_WAIT = 3'h4
    } ssci_state_type;

endpackage

/* File: hdl/ssci_loop_if.sv */
// signals between the serial core and the loop timing block
`timescale 1ns/1ps
interface ssci_loop_if;
    logic xtal_edge;
    logic rf_edge;
    logic locked;
    logic [14:0] ratio;
    logic lock_flag;
    logic ref_tog;
    logic div_tog;

    modport core
    (
        output xtal_edge,
        output rf_edge,
        output locked,
        output ratio,
        input lock_flag,
        input ref_tog,
        input div_tog
    );

    modport loop
    (
        input xtal_edge,
        input rf_edge,
        input locked,
        input ratio,
        output lock_flag,
        output ref_tog,
        output div_tog
    );
endinterface

/* File: hdl/ssci_loop_timing.sv */
// reference divider, prescaler, programmable divider and lock flag timer
`timescale 1ns/1ps
module ssci_loop_timing #(
    parameter int LOCK_SET_CYCLES = ssci_pkg::LOCK_SET_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    ssci_loop_if.loop lp
);
    localparam int REF_W = $clog2(ssci_pkg::XTAL_DIV);
    localparam int PRE_W = $clog2(ssci_pkg::PRESCALE);
    localparam int LCK_W = $clog2(LOCK_SET_CYCLES + 1);

    logic [REF_W-1:0] ref_cnt, next_ref_cnt;
    logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
    logic [14:0] n_cnt, next_n_cnt;
    logic [LCK_W-1:0] lock_cnt, next_lock_cnt;
    logic ref_tog, next_ref_tog;
    logic div_tog, next_div_tog;
    logic lock_flag, next_lock_flag;
    logic pre_tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_ref_cnt = ref_cnt;
        next_ref_tog = ref_tog;
        next_pre_cnt = pre_cnt;
        next_n_cnt = n_cnt;
        next_div_tog = div_tog;
        pre_tick = 1'b0;
        if (lp.xtal_edge)
        begin
            if (ref_cnt == REF_W'(ssci_pkg::XTAL_DIV - 1))
            begin
                next_ref_cnt = '0;
                next_ref_tog = ~ref_tog;
            end
            else
                next_ref_cnt = ref_cnt + 1'b1;
        end
        if (lp.rf_edge)
        begin
            if (pre_cnt == PRE_W'(ssci_pkg::PRESCALE - 1))
            begin
                next_pre_cnt = '0;
                pre_tick = 1'b1;
            end
            else
                next_pre_cnt = pre_cnt + 1'b1;
        end
        if (pre_tick)
        begin
            // ratio below 1 behaves as 1 rather than stalling
            if (n_cnt + 15'h0001 >= lp.ratio)
            begin
                next_n_cnt = '0;
                next_div_tog = ~div_tog;
            end
            else
                next_n_cnt = n_cnt + 15'h0001;
        end
        // set after hold time, clear at once
        next_lock_cnt = lock_cnt;
        next_lock_flag = lock_flag;
        if (!lp.locked)
        begin
            next_lock_cnt = '0;
            next_lock_flag = 1'b0;
        end
        else if (!lock_flag)
        begin
            if (lock_cnt == LCK_W'(LOCK_SET_CYCLES - 1))
                next_lock_flag = 1'b1;
            else
                next_lock_cnt = lock_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_cnt <= '0;
            ref_tog <= 1'b0;
            pre_cnt <= '0;
            n_cnt <= '0;
            div_tog <= 1'b0;
            lock_cnt <= '0;
            lock_flag <= 1'b0;
        end
        else
        begin
            ref_cnt <= next_ref_cnt;
            ref_tog <= next_ref_tog;
            pre_cnt <= next_pre_cnt;
            n_cnt <= next_n_cnt;
            div_tog <= next_div_tog;
            lock_cnt <= next_lock_cnt;
            lock_flag <= next_lock_flag;
        end
    end

    assign lp.ref_tog = ref_tog;
    assign lp.div_tog = div_tog;
    assign lp.lock_flag = lock_flag;
endmodule // ssci_loop_timing

/* File: hdl/ssci_top.sv */
// two-wire serial slave control interface of the frequency synthesizer
`timescale 1ns/1ps
// Overview of operation
// - answer address 11000 plus two select bits; eighth bit picks read or write.
// - write data bytes auto-increment through four registers in one transfer.
// - first data byte MSB 0 selects divider, 1 selects pump/test.
// - keep accepting data bytes until STOP, no readdressing needed.
// - fifteen-bit ratio: high byte low seven bits, then low byte.
// - reference equals crystal clock divided by 512.
// - input signal prescaled by 16 before the programmable divider.
// - pump byte: current select, test route, tristate, amplifier off bits.
// - current select 0 gives 50 uA, 1 gives 220 uA.
// - test route outputs reference on converter port, divided signal on seven.
// - tristate bit floats the pump output.
// - amplifier off bit disables the tuning drive output.
// - port byte maps ports seven..three, two spare, port zero.
// - ports seven to four drive open-collector when bit is 1.
// - ports three and zero drive current-limited when bit is 1.
// - all ports high impedance after power-on.
// - in read, acknowledge then shift status byte out MSB first.
// - send another byte only on controller acknowledge; else release data.
// - power flag set at power-up and low supply, cleared after read end.
// - lock flag in status bit 6, power flag in bit 7.
// - ports seven, five, four levels in status bits 5, 4, 3.
// - converter bands coded 100, 011, 010, 001, 000 highest first.
// - select bits come from address port voltage band, open gives 01.
// - lock flag set 1024-1152 us after lock, cleared within 128 us.
module ssci_top #(
    parameter int LOCK_SET_CYCLES = ssci_pkg::LOCK_SET_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic xtal_i,
    input wire logic rf_i,
    input wire logic lock_detect_i,
    input wire logic supply_low_i,
    input wire logic port_seven_i,
    input wire logic port_five_i,
    input wire logic port_four_i,
    input wire logic [1:0] addr_band_i,
    input wire logic [3:0] conv_cmp_i,
    output logic [5:0] port_drive_o,
    output logic [14:0] divider_ratio_o,
    output logic pump_current_select_o,
    output logic pump_tristate_o,
    output logic drive_amp_off_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 15;
    localparam int I_SCL = 14;
    localparam int I_SDA = 13;
    localparam int I_XTAL = 12;
    localparam int I_RF = 11;
    localparam int I_LOCK = 10;
    localparam int I_SUPLO = 9;
    localparam int I_P7 = 8;
    localparam int I_P5 = 7;
    localparam int I_P4 = 6;
    localparam int I_ADDR = 4;
    localparam int I_CONV = 0;

    logic [NPIN-1:0] pins, s1, s2, s3, filt, filt_q, next_filt;
    assign pins = {scl_i, sda_i, xtal_i, rf_i, lock_detect_i, supply_low_i,
                   port_seven_i, port_five_i, port_four_i, addr_band_i, conv_cmp_i};

    // a change counts only once stages two and three agree
    always_comb
    begin
        next_filt = (s2 & s3) | (filt & (s2 ^ s3));
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
            filt_q <= '0;
        end
        else
        begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            filt_q <= filt;
        end
    end

    logic scl_rise, scl_fall, sda_bit, start_cond, stop_cond;
    assign scl_rise = filt[I_SCL] & ~filt_q[I_SCL];
    assign scl_fall = ~filt[I_SCL] & filt_q[I_SCL];
    assign sda_bit = filt[I_SDA];
    assign start_cond = filt[I_SCL] & filt_q[I_SCL] & ~filt[I_SDA] & filt_q[I_SDA];
    assign stop_cond = filt[I_SCL] & filt_q[I_SCL] & filt[I_SDA] & ~filt_q[I_SDA];

    // ------------------------------------------------------------
    // loop timing
    // ------------------------------------------------------------
    ssci_loop_if lp ();
    assign lp.xtal_edge = filt[I_XTAL] & ~filt_q[I_XTAL];
    assign lp.rf_edge = filt[I_RF] & ~filt_q[I_RF];
    assign lp.locked = filt[I_LOCK];
    assign lp.ratio = divider_ratio_o;

    ssci_loop_timing #(
        .LOCK_SET_CYCLES(LOCK_SET_CYCLES)
    ) u_loop (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lp(lp.loop)
    );

    // ------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------
    logic por_flag, next_por_flag;
    logic [2:0] conv_code;
    logic [7:0] status;

    always_comb
    begin
        if (filt[I_CONV + 3])
            conv_code = ssci_pkg::CONV_B4;
        else if (filt[I_CONV + 2])
            conv_code = ssci_pkg::CONV_B3;
        else if (filt[I_CONV + 1])
            conv_code = ssci_pkg::CONV_B2;
        else if (filt[I_CONV])
            conv_code = ssci_pkg::CONV_B1;
        else
            conv_code = ssci_pkg::CONV_B0;
    end

    assign status = {por_flag, lp.lock_flag, filt[I_P7], filt[I_P5], filt[I_P4], conv_code};

    // ------------------------------------------------------------
    // serial protocol
    // ------------------------------------------------------------
    ssci_pkg::ssci_state_type state, next_state;
    logic [7:0] shift, next_shift;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [1:0] ptr, next_ptr, sel;
    logic first, next_first;
    logic rd_nack;
    logic drive_low, next_drive_low;
    logic [7:0] pump, next_pump;
    logic [7:0] port, next_port;
    logic [14:0] ratio, next_ratio;
    logic addr_match;

    // fixed upper bits plus select bits
    // select bits follow address port band
    assign addr_match = (shift[7:3] == ssci_pkg::ADDR_FIXED)
                        && (shift[2:1] == filt[I_ADDR +: 2]);

    always_comb
    begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_ptr = ptr;
        next_first = first;
        next_drive_low = drive_low;
        next_pump = pump;
        next_port = port;
        next_ratio = ratio;
        rd_nack = 1'b0;
        // first byte MSB picks the register
        sel = (first && shift[ssci_pkg::DATA_SEL_BIT]) ? ssci_pkg::IDX_PUMP
              : (first ? ssci_pkg::IDX_DIV_HI : ptr);
        case (state)
            ssci_pkg::SSCI_ADDR, ssci_pkg::SSCI_WR:
            begin
                if (scl_rise)
                begin
                    next_shift = {shift[6:0], sda_bit};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                else if (scl_fall && bit_cnt == ssci_pkg::BITS_PER_BYTE)
                begin
                    next_bit_cnt = '0;
                    if (state == ssci_pkg::SSCI_ADDR)
                    begin
                        next_drive_low = addr_match;
                        next_state = addr_match ? ssci_pkg::SSCI_ADDR_ACK
                                     : ssci_pkg::SSCI_WAIT;
                    end
                    else
                    begin
                        // every data byte acknowledged until STOP
                        next_drive_low = 1'b1;
                        next_state = ssci_pkg::SSCI_WR_ACK;
                        next_first = 1'b0;
                        next_ptr = sel + 2'h1;
                        case (sel)
                            ssci_pkg::IDX_DIV_HI: next_ratio = {shift[6:0], ratio[7:0]};
                            ssci_pkg::IDX_DIV_LO: next_ratio = {ratio[14:8], shift};
                            ssci_pkg::IDX_PUMP: next_pump = shift;
                            default: next_port = shift;
                        endcase
                    end
                end
            end
            ssci_pkg::SSCI_ADDR_ACK:
            begin
                if (scl_fall)
                begin
                    if (shift[0] == ssci_pkg::RW_READ)
                    begin
                        // status out MSB first after acknowledge
                        next_shift = status;
                        next_drive_low = ~status[7];
                        next_state = ssci_pkg::SSCI_RD;
                    end
                    else
                    begin
                        next_drive_low = 1'b0;
                        next_first = 1'b1;
                        next_state = ssci_pkg::SSCI_WR;
                    end
                end
            end
            ssci_pkg::SSCI_WR_ACK:
            begin
                if (scl_fall)
                begin
                    next_drive_low = 1'b0;
                    next_state = ssci_pkg::SSCI_WR;
                end
            end
            ssci_pkg::SSCI_RD:
            begin
                if (scl_fall)
                begin
                    if (bit_cnt[2:0] == ssci_pkg::LAST_BIT)
                    begin
                        next_drive_low = 1'b0;
                        next_bit_cnt = '0;
                        next_state = ssci_pkg::SSCI_RD_ACK;
                    end
                    else
                    begin
                        next_shift = {shift[6:0], 1'b0};
                        next_drive_low = ~shift[6];
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end
            end
            ssci_pkg::SSCI_RD_ACK:
            begin
                // no acknowledge ends the read, line stays released
                if (scl_rise && sda_bit)
                begin
                    rd_nack = 1'b1;
                    next_state = ssci_pkg::SSCI_WAIT;
                end
                else if (scl_fall)
                begin
                    next_shift = status;
                    next_drive_low = ~status[7];
                    next_state = ssci_pkg::SSCI_RD;
                end
            end
            default:
            begin
                next_drive_low = 1'b0;
            end
        endcase
        if (start_cond)
        begin
            next_state = ssci_pkg::SSCI_ADDR;
            next_bit_cnt = '0;
            next_drive_low = 1'b0;
        end
        else if (stop_cond)
        begin
            next_state = ssci_pkg::SSCI_IDLE;
            next_drive_low = 1'b0;
        end
        // low supply sets, end of read clears; set wins
        next_por_flag = filt[I_SUPLO] | (por_flag & ~rd_nack);
    end

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    logic [5:0] next_port_drive;
    always_comb
    begin
        next_port_drive = {port[ssci_pkg::PB_SEVEN], port[ssci_pkg::PB_CONV],
                           port[ssci_pkg::PB_FIVE], port[ssci_pkg::PB_FOUR],
                           port[ssci_pkg::PB_ADDR], port[ssci_pkg::PB_ZERO]};
        // test route replaces two port drives
        if (pump[ssci_pkg::TEST_ROUTE_BIT])
        begin
            next_port_drive[5] = lp.div_tog;
            next_port_drive[4] = lp.ref_tog;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ssci_pkg::SSCI_IDLE;
            shift <= '0;
            bit_cnt <= '0;
            ptr <= ssci_pkg::IDX_DIV_HI;
            first <= 1'b0;
            drive_low <= 1'b0;
            por_flag <= 1'b1;
            pump <= ssci_pkg::PUMP_RESET;
            port <= ssci_pkg::PORT_RESET;
            ratio <= ssci_pkg::RATIO_RESET;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            port_drive_o <= '0;
            divider_ratio_o <= ssci_pkg::RATIO_RESET;
            pump_current_select_o <= 1'b0;
            pump_tristate_o <= 1'b0;
            drive_amp_off_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            ptr <= next_ptr;
            first <= next_first;
            drive_low <= next_drive_low;
            por_flag <= next_por_flag;
            pump <= next_pump;
            port <= next_port;
            ratio <= next_ratio;
            // open drain: only ever pulls low
            sda_o <= 1'b0;
            sda_oe_o <= next_drive_low;
            port_drive_o <= next_port_drive;
            divider_ratio_o <= next_ratio;
            pump_current_select_o <= next_pump[ssci_pkg::PUMP_CURRENT_BIT];
            pump_tristate_o <= next_pump[ssci_pkg::PUMP_TRISTATE_BIT];
            drive_amp_off_o <= next_pump[ssci_pkg::DRIVE_AMP_OFF_BIT];
        end
    end
endmodule // ssci_top

/* File: test/ssci_top_chk.sv */
// concurrent checks on the serial control interface pins
`timescale 1ns/1ps
module ssci_top_chk #(
    parameter int LOCK_SET_CYCLES = 16
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [5:0] port_drive_o,
    input wire logic [14:0] divider_ratio_o,
    input wire logic drive_amp_off_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // an ack or zero bit must outlive the rest of the low phase
    sequence oe_held;
        sda_oe_o [*8];
    endsequence
    chk_reset_ports: assert property ($fell(rst_i) |-> port_drive_o == 6'h00)
        else $error("ports driven after reset");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !sda_oe_o && !drive_amp_off_o)
        else $error("outputs active after reset");
    chk_pull_low: assert property (sda_oe_o |-> sda_o == 1'h0)
        else $error("data line driven high");
    chk_stable_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data changed while clock high");
    chk_drive_late: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("drive began too soon after clock fall");
    chk_drive_stands: assert property ($rose(sda_oe_o) |-> oe_held)
        else $error("low bit released early");
    chk_release_low: assert property ($fell(sda_oe_o) |-> !scl_i)
        else $error("data released while clock high");
    chk_config_steady:
        assert property (scl_i && sda_i && $past(scl_i, 8) && $past(sda_i, 8)
            |-> $stable(divider_ratio_o))
        else $error("ratio moved late in a clock high phase");
endmodule // ssci_top_chk

bind ssci_top ssci_top_chk #(.LOCK_SET_CYCLES(LOCK_SET_CYCLES)) u_chk (.clk_i, .rst_i,
    .scl_i, .sda_i, .sda_o, .sda_oe_o, .port_drive_o, .divider_ratio_o, .drive_amp_off_o);

/* File: test/ssci_ctl_model.sv */
// two-wire bus controller model, 20 clock bit period
`timescale 1ns/1ps
module ssci_ctl_model
(
    input wire logic clk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic hold_low = 1'h0;
    // released line floats to the pull-up level
    assign sda_o = !(hold_low || sda_oe_i);
    initial
        scl_o = 1'h1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start();
        hold_low <= 1'h1;
        tick(10);
        scl_o <= 1'h0;
    endtask
    task automatic stop();
        tick(3);
        hold_low <= 1'h1;
        tick(7);
        scl_o <= 1'h1;
        tick(10);
        hold_low <= 1'h0;
        tick(10);
    endtask
    // data moves mid low phase, away from either clock edge
    task automatic xbit(input logic b, output logic r);
        tick(3);
        hold_low <= !b;
        tick(7);
        scl_o <= 1'h1;
        tick(5);
        r = sda_o;
        tick(5);
        scl_o <= 1'h0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
        output logic ack_out);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        // low asks for more, high ends a read
        xbit(ack_in, ack_out);
    endtask
endmodule // ssci_ctl_model

/* File: test/ssci_top_tb.sv */
// self-checking bench for the synthesizer serial control interface
`timescale 1ns/1ps
module ssci_top_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, xtal_i = 1'h0, rf_i = 1'h0, supply_low_i = 1'h0;
    logic lock_detect_i = 1'h1, port_seven_i = 1'h1, port_five_i = 1'h0, port_four_i = 1'h1;
    logic scl_i, sda_i, sda_o, sda_oe_o, pump_current_select_o, pump_tristate_o;
    logic drive_amp_off_o, a;
    logic [1:0] addr_band_i = 2'h1;
    logic [3:0] conv_cmp_i = 4'h0;
    logic [5:0] port_drive_o;
    logic [7:0] q;
    logic [14:0] divider_ratio_o;
    logic ph = 1'h0;
    int fails = 0, comparisons = 0;
    // a pin toggling every clock never passes the agree filter, so run at a quarter
    localparam int PIN_PER = 4;
    always #50 clk_i = !clk_i;
    always @(posedge clk_i)
    begin
        ph <= !ph;
        if (ph)
        begin
            xtal_i <= !xtal_i;
            rf_i <= !rf_i;
        end
    end
    ssci_top #(.LOCK_SET_CYCLES(16)) DUT (.clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .xtal_i, .rf_i, .lock_detect_i, .supply_low_i, .port_seven_i, .port_five_i,
        .port_four_i, .addr_band_i, .conv_cmp_i, .port_drive_o, .divider_ratio_o,
        .pump_current_select_o, .pump_tristate_o, .drive_amp_off_o);
    ssci_ctl_model ctl (.clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic send(input logic [7:0] d);
        ctl.xbyte(d, 1'h1, q, a);
    endtask
    // cycles between two toggles of one port drive, bounded
    task automatic gap(input int b, output int n);
        logic prev;
        int t;
        t = 0;
        n = 0;
        prev = port_drive_o[b];
        while (t < 2 && n < 5000)
        begin
            @(posedge clk_i);
            n++;
            if (port_drive_o[b] !== prev)
            begin
                t++;
                if (t == 1)
                    n = 0;
            end
            prev = port_drive_o[b];
        end
    endtask
    task automatic t_write();
        ctl.start();
        send(8'hC2);
        check(a, 1'h0);
        send(8'h12);
        send(8'h34);
        check(divider_ratio_o, 15'h1234);
        send(8'hDF);
        send(8'hF9);
        check({pump_current_select_o, pump_tristate_o, drive_amp_off_o}, 3'h7);
        check(port_drive_o, 6'h3F);
        send(8'h05);
        check(divider_ratio_o, 15'h0534);
        ctl.stop();
        ctl.start();
        send(8'hC2);
        // partial write opens on the pump byte
        send(8'h8E);
        send(8'h40);
        ctl.stop();
        check({pump_current_select_o, pump_tristate_o, drive_amp_off_o}, 3'h0);
        check(port_drive_o, 6'h10);
    endtask
    task automatic t_addr();
        logic [7:0] ad [4] = '{8'hC6, 8'hC0, 8'hE2, 8'h42};
        foreach (ad[i])
        begin
            ctl.start();
            send(ad[i]);
            check(a, 1'h1);
            send(8'h00);
            ctl.stop();
        end
        check(divider_ratio_o, 15'h0534);
        addr_band_i <= 2'h3;
        ctl.start();
        send(8'hC6);
        check(a, 1'h0);
        ctl.stop();
        addr_band_i <= 2'h1;
    endtask
    task automatic t_read();
        check(port_drive_o & 6'h2C, 6'h00);
        for (int k = 0; k < 5; k++)
        begin
            conv_cmp_i <= 4'((1 << k) - 1);
            ctl.start();
            send(8'hC3);
            check(a, 1'h0);
            ctl.xbyte(8'hFF, 1'h0, q, a);
            check(q, {(k == 0), 4'hD, 3'(k)});
            send(8'hFF);
            check(q, {(k == 0), 4'hD, 3'(k)});
            ctl.stop();
        end
        supply_low_i <= 1'h1;
        lock_detect_i <= 1'h0;
        ctl.tick(10);
        supply_low_i <= 1'h0;
        ctl.start();
        send(8'hC3);
        send(8'hFF);
        ctl.stop();
        check(q, 8'hAC);
    endtask
    task automatic t_route();
        int n;
        ctl.start();
        send(8'hC2);
        send(8'hAE);
        send(8'h00);
        send(8'h00);
        send(8'h02);
        ctl.stop();
        gap(4, n);
        check(15'(n), 15'(ssci_pkg::XTAL_DIV * PIN_PER));
        gap(5, n);
        check(15'(n), 15'(2 * ssci_pkg::PRESCALE * PIN_PER));
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        ctl.tick(40);
        check(port_drive_o, 6'h00);
        t_write();
        t_addr();
        t_read();
        t_route();
        conclude();
    end
    // whole run is near 10500 cycles
    initial
    begin
        repeat (40000) @(posedge clk_i);
        fails++;
        conclude();
    end
endmodule // ssci_top_tb
